// ### inc/romseq_pkg.sv
// romseq_pkg: shared constants, enums and structs of the reader mode sequencer
// assumes one clock domain; serial framing lives outside this block
package romseq_pkg;
  localparam int unsigned CNT_W = 7;
  localparam logic [CNT_W-1:0] TEST_BLOCK_LEN = 7'h64;
  localparam logic [CNT_W-1:0] PCT_SCALE = 7'h64;
  localparam int unsigned EMPTY_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned SLAVE_MAX = 16;
  localparam int unsigned NETCFG_W = 8;
  // arbitrary neutral identity value
  localparam logic [15:0] DEVICE_TYPE_CODE = 16'h1234;

  typedef enum logic [1:0] {MODE_TEST, MODE_ONLINE, MODE_AUTO} romseq_mode_e;
  typedef enum logic [1:0] {ROLE_DISABLED, ROLE_MASTER, ROLE_SLAVE} romseq_role_e;
  typedef enum logic [2:0] {
    MSG_NONE, MSG_CODE, MSG_NOREAD, MSG_STATS, MSG_DEVTYPE, MSG_SLAVE
  } romseq_msg_e;
  typedef enum logic [2:0] {
    HCMD_NONE, HCMD_DEVTYPE, HCMD_AUTODETECT, HCMD_CFGWORD, HCMD_CFGCOMMIT
  } romseq_hcmd_e;

  typedef struct packed {
    romseq_msg_e kind;
    logic [15:0] payload;
  } romseq_msg_s;

  typedef struct packed {
    romseq_hcmd_e cmd;
    logic [ADDR_W-1:0] index;
    logic [NETCFG_W-1:0] data;
  } romseq_hreq_s;

  typedef struct packed {
    romseq_role_e role;
    logic [ADDR_W-1:0] address;
  } romseq_role_s;
endpackage

// ### design/romseq_pct.sv
// romseq_pct: integer percentage of good reads in a test block
// assumes attempts is nonzero whenever start is pulsed
`timescale 1ns/10ps
module romseq_pct
  import romseq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire logic start,
  input wire logic [CNT_W-1:0] good,
  input wire logic [CNT_W-1:0] attempts,
  // result
  output logic done,
  output logic [CNT_W-1:0] pct
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [13:0] rem;
    logic [CNT_W-1:0] den;
    logic [CNT_W-1:0] quo;
  } romseq_pct_s;
  romseq_pct_s st_ff, nxt_st;

  // repeated subtraction; one block of 100 takes at most 101 cycles
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (start) begin
      nxt_st.busy = 1'b1;
      nxt_st.rem = 14'(good) * 14'(PCT_SCALE);
      nxt_st.den = attempts;
      nxt_st.quo = '0;
    end else if (st_ff.busy) begin
      if (st_ff.rem >= 14'(st_ff.den)) begin
        nxt_st.rem = st_ff.rem - 14'(st_ff.den);
        nxt_st.quo = st_ff.quo + 7'h01;
      end else begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done = st_ff.done;
  assign pct = st_ff.quo;
endmodule

// ### design/romseq_top.sv
// romseq_top: read cycle sequencer for test, online and automatic modes
// assumes a decoder answers each scan request and a serial framer takes messages
// Notes on behaviour
// - in test mode scans are requested continuously with no trigger.
// - in test mode a data and statistics report goes out per block of 100 attempts; attempts completed while the percentage is computed are discarded.
// - the statistics value is the percentage of good reads in that block.
// - in online mode the differential presence pair gates the read cycle.
// - in online mode scanning runs while the presence sensor shows an object, until the first good read.
// - an online cycle that decoded sends the code data.
// - an online cycle without a decode sends a no-read message.
// - in automatic mode the sensor is ignored and a code in the zone opens a cycle.
// - an automatic cycle ends after a set number of consecutive empty scans.
// - automatic mode sends the data of the code that opens a cycle and nothing for an empty cycle.
// - a device type code is held and can be read by the host.
// - network configuration is accepted only in the master role.
// - autodetect makes the master report every slave found on the network.
// - on commit the master stores the complete transferred configuration.
// - the reader holds a role of master, addressed slave or disabled.
`timescale 1ns/10ps
module romseq_top
  import romseq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration
  input wire romseq_mode_e modeSel,
  input wire romseq_role_s network_role_select,
  input wire logic [EMPTY_W-1:0] emptyScanLimit,
  // presence sensor pins
  input wire logic presence_trigger_pos,
  input wire logic presence_trigger_neg,
  // decoder
  output logic scanReq,
  input wire logic scanDone,
  input wire logic scanGood,
  input wire logic [DATA_W-1:0] scanData,
  // reader network presence map
  input wire logic [SLAVE_MAX-1:0] slavePresent,
  // host requests
  input wire romseq_hreq_s hostReq,
  // messages to host
  output romseq_msg_s msgOut,
  output logic msgValid,
  input wire logic msgReady,
  // stored network configuration and read cycle state
  output logic [SLAVE_MAX*NETCFG_W-1:0] netCfg,
  output logic cycleOpen
);
  typedef struct packed {
    logic [1:0] trigPos;
    logic [1:0] trigNeg;
    logic cycle;
    logic hadGood;
    logic [DATA_W-1:0] lastData;
    logic [EMPTY_W-1:0] empties;
    logic [CNT_W-1:0] attempts;
    logic [CNT_W-1:0] goods;
    logic statPending;
    logic scanReq;
    logic msgValid;
    romseq_msg_s msg;
    logic detecting;
    logic [ADDR_W-1:0] detIdx;
    logic [SLAVE_MAX*NETCFG_W-1:0] staged;
    logic [SLAVE_MAX*NETCFG_W-1:0] cfg;
  } romseq_top_s;
  romseq_top_s st_ff, nxt_st;

  logic pctDone;
  logic [CNT_W-1:0] pctVal;
  logic pctStart;
  logic [CNT_W-1:0] pctGood;
  logic present;
  logic isMaster;
  logic msgFree;

  romseq_pct u_pct (
    .clk(clk),
    .rst_n(rst_n),
    .start(pctStart),
    .good(pctGood),
    .attempts(TEST_BLOCK_LEN),
    .done(pctDone),
    .pct(pctVal)
  );

  // only second stage is read; pair must disagree to count as a valid level
  assign present = st_ff.trigPos[1] & ~st_ff.trigNeg[1];
  assign isMaster = (network_role_select.role == ROLE_MASTER);
  assign msgFree = !st_ff.msgValid || msgReady;
  assign pctStart = (modeSel == MODE_TEST) && scanDone &&
                    (st_ff.attempts == TEST_BLOCK_LEN - 7'h01);
  // the closing attempt of the block is counted here, it is not yet in the register
  assign pctGood = st_ff.goods + CNT_W'(scanGood);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.trigPos = {st_ff.trigPos[0], presence_trigger_pos};
    nxt_st.trigNeg = {st_ff.trigNeg[0], presence_trigger_neg};
    if (st_ff.msgValid && msgReady) begin
      nxt_st.msgValid = 1'b0;
    end
    nxt_st.scanReq = 1'b0;
    // decoder results are never stalled; a busy message port drops the newer report
    case (modeSel)
      MODE_TEST: begin
        nxt_st.cycle = 1'b0;
        nxt_st.scanReq = 1'b1;
        if (scanDone) begin
          nxt_st.attempts = st_ff.attempts + 7'h01;
          if (scanGood) begin
            nxt_st.goods = st_ff.goods + 7'h01;
            nxt_st.lastData = scanData;
          end
          if (pctStart) begin
            nxt_st.statPending = 1'b1;
          end
        end
        if (pctDone) begin
          nxt_st.attempts = '0;
          nxt_st.goods = '0;
        end
        if (st_ff.statPending && pctDone && msgFree) begin
          nxt_st.statPending = 1'b0;
          nxt_st.msgValid = 1'b1;
          nxt_st.msg.kind = MSG_STATS;
          nxt_st.msg.payload = {st_ff.lastData, 1'b0, pctVal};
        end else if (pctDone) begin
          nxt_st.statPending = 1'b0;
        end
      end
      MODE_ONLINE: begin
        nxt_st.attempts = '0;
        nxt_st.goods = '0;
        if (present && !st_ff.cycle) begin
          nxt_st.cycle = 1'b1;
          nxt_st.hadGood = 1'b0;
        end
        if (st_ff.cycle) begin
          nxt_st.scanReq = present && !st_ff.hadGood;
          if (scanDone && scanGood) begin
            nxt_st.hadGood = 1'b1;
            nxt_st.lastData = scanData;
          end
          if (!present) begin
            nxt_st.cycle = 1'b0;
            if (msgFree) begin
              nxt_st.msgValid = 1'b1;
              if (st_ff.hadGood) begin
                nxt_st.msg.kind = MSG_CODE;
                nxt_st.msg.payload = {8'h00, st_ff.lastData};
              end else begin
                nxt_st.msg.kind = MSG_NOREAD;
                nxt_st.msg.payload = '0;
              end
            end
          end
        end
      end
      MODE_AUTO: begin
        nxt_st.attempts = '0;
        nxt_st.goods = '0;
        nxt_st.scanReq = 1'b1;
        if (scanDone) begin
          if (scanGood) begin
            nxt_st.empties = '0;
            if (!st_ff.cycle) begin
              nxt_st.cycle = 1'b1;
              if (msgFree) begin
                nxt_st.msgValid = 1'b1;
                nxt_st.msg.kind = MSG_CODE;
                nxt_st.msg.payload = {8'h00, scanData};
              end
            end
          end else if (st_ff.cycle) begin
            nxt_st.empties = st_ff.empties + 8'h01;
            if (st_ff.empties + 8'h01 >= emptyScanLimit) begin
              nxt_st.cycle = 1'b0;
              nxt_st.empties = '0;
            end
          end
        end
      end
      default: begin
        nxt_st.cycle = 1'b0;
      end
    endcase
    // host side network handling
    if (st_ff.detecting) begin
      if (msgFree && !nxt_st.msgValid) begin
        if (slavePresent[st_ff.detIdx]) begin
          nxt_st.msgValid = 1'b1;
          nxt_st.msg.kind = MSG_SLAVE;
          nxt_st.msg.payload = {12'h000, st_ff.detIdx};
        end
        nxt_st.detIdx = st_ff.detIdx + 4'h1;
        if (st_ff.detIdx == 4'(SLAVE_MAX - 1)) begin
          nxt_st.detecting = 1'b0;
        end
      end
    end else begin
      case (hostReq.cmd)
        HCMD_DEVTYPE: begin
          if (msgFree && !nxt_st.msgValid) begin
            nxt_st.msgValid = 1'b1;
            nxt_st.msg.kind = MSG_DEVTYPE;
            nxt_st.msg.payload = DEVICE_TYPE_CODE;
          end
        end
        HCMD_AUTODETECT: begin
          if (isMaster) begin
            nxt_st.detecting = 1'b1;
            nxt_st.detIdx = '0;
          end
        end
        HCMD_CFGWORD: begin
          if (isMaster) begin
            nxt_st.staged[hostReq.index*NETCFG_W +: NETCFG_W] = hostReq.data;
          end
        end
        HCMD_CFGCOMMIT: begin
          if (isMaster) begin
            nxt_st.cfg = st_ff.staged;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign scanReq = st_ff.scanReq;
  assign msgOut = st_ff.msg;
  assign msgValid = st_ff.msgValid;
  assign netCfg = st_ff.cfg;
  assign cycleOpen = st_ff.cycle;
endmodule

// ### dv/romseq_host.sv
// romseq_host: host end of the message link, collects every message taken
// assumes msgValid and msgOut stay put until msgReady takes them
`timescale 1ns/10ps
module romseq_host
  import romseq_pkg::*;
(
  // clock
  input wire logic clk,
  // message link
  input wire logic msgValid,
  input wire romseq_msg_s msgOut,
  output logic msgReady,
  // bench control
  input wire logic stall
);
  romseq_msg_s got[$];
  // a slow host holds ready low, the sender must wait
  assign msgReady = !stall;
  always @(posedge clk) begin
    if (msgValid && msgReady) begin
      got.push_back(msgOut);
    end
  end
endmodule

// ### dv/romseq_top_sva.sv
// romseq_top_sva: port checks of the read mode sequencer
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module romseq_top_sva
  import romseq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // inputs
  input wire romseq_mode_e modeSel,
  input wire romseq_role_s network_role_select,
  input wire romseq_hreq_s hostReq,
  input wire logic scanDone,
  input wire logic scanGood,
  input wire logic [DATA_W-1:0] scanData,
  input wire logic msgReady,
  // outputs
  input wire logic scanReq,
  input wire romseq_msg_s msgOut,
  input wire logic msgValid,
  input wire logic [SLAVE_MAX*NETCFG_W-1:0] netCfg,
  input wire logic cycleOpen
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic idle;
  logic master;
  assign idle = modeSel == romseq_mode_e'(2'h3);
  assign master = network_role_select.role == ROLE_MASTER;

  a_msg_hold: assert property (msgValid && !msgReady |=> msgValid && $stable(msgOut))
    else $error("waiting message not held");
  a_test_scan: assert property (modeSel == MODE_TEST [*4] |-> scanReq)
    else $error("test mode not scanning");
  a_devtype_reply: assert property (idle && !master && !msgValid
    && hostReq.cmd == HCMD_DEVTYPE |=> msgValid && msgOut == {MSG_DEVTYPE, DEVICE_TYPE_CODE})
    else $error("device type reply wrong");
  a_auto_open: assert property (modeSel == MODE_AUTO && scanDone && scanGood
    && !cycleOpen && !msgValid
    |=> cycleOpen && msgValid && msgOut == {MSG_CODE, 8'h00, $past(scanData)})
    else $error("auto cycle open wrong");
  a_online_close: assert property (modeSel == MODE_ONLINE && $fell(cycleOpen)
    |-> ##[0:3] msgValid && (msgOut.kind == MSG_CODE || msgOut.kind == MSG_NOREAD))
    else $error("online cycle without result");
  a_nonmaster_quiet: assert property (idle && !master && !msgValid
    && hostReq.cmd == HCMD_AUTODETECT |=> !msgValid [*3])
    else $error("autodetect answered off master");
  a_netcfg_hold: assert property (!master |=> $stable(netCfg))
    else $error("config changed off master");
  a_stats_range: assert property (msgValid && msgOut.kind == MSG_STATS
    |-> !msgOut.payload[7] && msgOut.payload[6:0] <= 7'h64)
    else $error("statistics out of range");
endmodule

bind romseq_top romseq_top_sva romseq_top_sva_i (.clk(clk), .rst_n(rst_n), .modeSel(modeSel),
  .network_role_select(network_role_select), .hostReq(hostReq), .scanDone(scanDone),
  .scanGood(scanGood), .scanData(scanData), .msgReady(msgReady), .scanReq(scanReq),
  .msgOut(msgOut), .msgValid(msgValid), .netCfg(netCfg), .cycleOpen(cycleOpen));

// ### dv/tb.sv
// tb: self-checking bench of the read mode sequencer
// assumes the bench plays decoder, sensor and host requests
`timescale 1ns/10ps
module tb
  import romseq_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  romseq_mode_e modeSel = romseq_mode_e'(2'h3);
  romseq_role_s netRole = '{ROLE_SLAVE, 4'h1};
  logic [7:0] emptyLim = 8'h01;
  logic trigPos = 1'b0;
  logic trigNeg = 1'b1;
  logic scanReq;
  logic scanDone = 1'b0;
  logic scanGood = 1'b0;
  logic [7:0] scanData = 8'h00;
  logic [15:0] slavePresent = 16'h0000;
  romseq_hreq_s hostReq = '0;
  romseq_msg_s msgOut;
  logic msgValid;
  logic msgReady;
  logic stall = 1'b0;
  logic [127:0] netCfg;
  logic cycleOpen;
  int mismatches = 0;
  int checked = 0;

  always #2.5 clk = ~clk;

  romseq_top romseq_top_i (.clk(clk), .rst_n(rst_n), .modeSel(modeSel),
    .network_role_select(netRole), .emptyScanLimit(emptyLim), .presence_trigger_pos(trigPos),
    .presence_trigger_neg(trigNeg), .scanReq(scanReq), .scanDone(scanDone),
    .scanGood(scanGood), .scanData(scanData), .slavePresent(slavePresent),
    .hostReq(hostReq), .msgOut(msgOut), .msgValid(msgValid), .msgReady(msgReady),
    .netCfg(netCfg), .cycleOpen(cycleOpen));
  romseq_host romseq_host_i (.clk(clk), .msgValid(msgValid), .msgOut(msgOut),
    .msgReady(msgReady), .stall(stall));

  // checks land 1 ns after the edge so registered outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [18:0] g, input logic [18:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [18:0] nMsg();
    return 19'(romseq_host_i.got.size());
  endfunction
  task automatic getMsg(output romseq_msg_s m);
    for (int i = 0; i < 400 && nMsg() == 0; i++) cyc(1);
    m = nMsg() > 0 ? romseq_host_i.got.pop_front() : '0;
  endtask
  task automatic req(input romseq_hcmd_e c, input logic [3:0] i, input logic [7:0] d);
    @(posedge clk);
    hostReq <= '{c, i, d};
    @(posedge clk);
    hostReq <= '0;
  endtask
  task automatic scan(input logic g, input logic [7:0] d);
    @(posedge clk);
    scanDone <= 1'b1;
    scanGood <= g;
    scanData <= d;
    @(posedge clk);
    scanDone <= 1'b0;
  endtask
  task automatic sensor(input logic on);
    @(posedge clk);
    trigPos <= on;
    trigNeg <= !on;
  endtask
  task automatic waitOpen(input logic v);
    for (int i = 0; i < 40 && cycleOpen !== v; i++) cyc(1);
    chk(cycleOpen, v);
  endtask
  task automatic setMode(input romseq_mode_e md);
    @(posedge clk);
    modeSel <= md;
  endtask

  task automatic tDevType();
    romseq_msg_s m;
    req(HCMD_DEVTYPE, 4'h0, 8'h00);
    getMsg(m);
    chk(m, {MSG_DEVTYPE, DEVICE_TYPE_CODE});
  endtask
  task automatic tTest();
    romseq_msg_s m;
    setMode(MODE_TEST);
    cyc(6);
    chk(scanReq, 1'b1);
    for (int i = 0; i < 100; i++) scan(i % 4 != 0, 8'(i));
    getMsg(m);
    chk(m, {MSG_STATS, 16'h634b});
    setMode(romseq_mode_e'(2'h3));
  endtask
  task automatic tOnline();
    romseq_msg_s m;
    setMode(MODE_ONLINE);
    trigPos <= 1'b1;
    cyc(6);
    chk(cycleOpen, 1'b0);
    sensor(1'b1);
    waitOpen(1'b1);
    cyc(2);
    chk(scanReq, 1'b1);
    scan(1'b1, 8'h5a);
    sensor(1'b0);
    getMsg(m);
    chk(m, {MSG_CODE, 16'h005a});
    waitOpen(1'b0);
    sensor(1'b1);
    waitOpen(1'b1);
    scan(1'b0, 8'h11);
    sensor(1'b0);
    getMsg(m);
    chk(m.kind, MSG_NOREAD);
  endtask
  task automatic tAuto();
    romseq_msg_s m;
    setMode(MODE_AUTO);
    emptyLim <= 8'h03;
    sensor(1'b1);
    cyc(6);
    chk(cycleOpen, 1'b0);
    scan(1'b1, 8'h3c);
    getMsg(m);
    chk(m, {MSG_CODE, 16'h003c});
    scan(1'b1, 8'h77);
    scan(1'b0, 8'h00);
    scan(1'b0, 8'h00);
    cyc(4);
    chk(cycleOpen, 1'b1);
    chk(nMsg(), 19'h0);
    scan(1'b0, 8'h00);
    waitOpen(1'b0);
    cyc(8);
    chk(nMsg(), 19'h0);
    sensor(1'b0);
    setMode(romseq_mode_e'(2'h3));
  endtask
  task automatic tNet();
    romseq_msg_s m;
    @(posedge clk);
    netRole <= '{ROLE_DISABLED, 4'h0};
    slavePresent <= 16'h8005;
    req(HCMD_AUTODETECT, 4'h0, 8'h00);
    req(HCMD_CFGWORD, 4'h3, 8'ha5);
    req(HCMD_CFGCOMMIT, 4'h0, 8'h00);
    cyc(30);
    chk(nMsg(), 19'h0);
    chk(19'(netCfg[31:24]), 19'h0);
    @(posedge clk);
    netRole <= '{ROLE_MASTER, 4'h0};
    stall <= 1'b1;
    req(HCMD_AUTODETECT, 4'h0, 8'h00);
    cyc(10);
    @(posedge clk);
    stall <= 1'b0;
    // slaves are reported in rising index order
    for (int i = 0; i < SLAVE_MAX; i++) begin
      if (slavePresent[i]) begin
        getMsg(m);
        chk(m, {MSG_SLAVE, 16'(i)});
      end
    end
    cyc(20);
    req(HCMD_CFGWORD, 4'h3, 8'ha5);
    req(HCMD_CFGWORD, 4'hf, 8'h3c);
    req(HCMD_CFGCOMMIT, 4'h0, 8'h00);
    cyc(3);
    chk(19'(netCfg[31:24]), 19'ha5);
    chk(19'(netCfg[127:120]), 19'h3c);
  endtask

  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    cyc(20);
    @(posedge clk);
    rst_n <= 1'b1;
    cyc(4);
    tDevType();
    tTest();
    tOnline();
    tAuto();
    tNet();
    results();
  end
  // about twenty times the expected run
  initial begin
    #50000;
    mismatches++;
    results();
  end
endmodule
